// File: rtl/stc_timer.sv
// Sixteen-bit timer/counter with prescaler, overflow interrupt and special-event reset
// What this block does
// - Clock source clear: count once per instruction cycle, system clock over four.
// - Clock source set: count rising edges of external input or low-power oscillator.
// - Prescale field 00,01,10,11 divides count clock by 1,2,4,8.
// - Sync bit set bypasses external synchronisation; clear synchronises; ignored internally.
// - Counter stopped after reset; on bit 0 starts it, clearing halts it.
// - Control bit 7 picks one 16-bit access or two 8-bit accesses.
// - Time-base field: 1x both units, 01 enhanced unit, 00 other timer.
// - Count is sixteen bits in readable, writable low and high bytes.
// - Rollover from ffff to 0000 latches the overflow flag.
// - Overflow interrupt raised only while its enable bit is set.
// - Special-event trigger in compare mode 1011 resets the counter.
// - Special-event reset never sets the overflow flag.
// - Software write in the trigger cycle wins over the reset.
// - In special-event mode compare value is the period; count restarts on match.
// - Oscillator enable forces both oscillator pins to inputs regardless of direction.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module stc_timer (
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   reset_n_in,
  // Register port
  input  wire stc_pkg::stc_req_s      req_in,
  output logic [7:0]                  rdata_out,
  // External count sources (asynchronous pins)
  input  wire logic                   ext_count_input_in,
  input  wire logic                   lowpower_osc_in,
  // Capture/compare unit side
  input  wire logic                   special_trigger_in,
  output logic [15:0]                 count_out,
  output stc_pkg::stc_timebase_s      timebase_out,
  // Oscillator pin direction control
  input  wire logic [1:0]             port_direction_in,
  output logic [1:0]                  osc_pin_input_out,
  // Interrupt
  output logic                        irq_out
);

  // Register state
  logic [7:0]  ctrl_q,    ctrl_d;
  logic [7:0]  aux_q,     aux_d;
  logic [7:0]  mask_q,    mask_d;
  logic [7:0]  stat_q,    stat_d;
  logic [15:0] count_q,   count_d;
  logic [15:0] cmp_q,     cmp_d;
  logic [7:0]  hi_buf_q,  hi_buf_d;
  logic [7:0]  rd_buf_q,  rd_buf_d;
  logic [7:0]  rdata_q,   rdata_d;
  logic [1:0]  div4_q,    div4_d;
  logic [2:0]  pre_q,     pre_d;
  logic [2:0]  ext_sync_q;
  logic        ext_prev_q;
  logic        raw_prev_q;

  // Control fields
  wire logic       counter_on          = ctrl_q[stc_pkg::CTL_ON_BIT];
  wire logic       clock_source_select = ctrl_q[stc_pkg::CTL_CS_BIT];
  wire logic       ext_sync_bypass     = ctrl_q[stc_pkg::CTL_SYNC_BIT];
  wire logic       wide_access_enable  = ctrl_q[stc_pkg::CTL_WIDE_BIT];
  wire logic [1:0] prescale_select     = ctrl_q[stc_pkg::CTL_PS_LSB +: 2];
  wire logic       timebase_select_hi  = ctrl_q[stc_pkg::CTL_TB_HI_BIT];
  wire logic       timebase_select_lo  = ctrl_q[stc_pkg::CTL_TB_LO_BIT];
  wire logic       lowpower_osc_enable = aux_q[stc_pkg::AUX_OSC_BIT];
  wire logic [3:0] compare_unit_mode   = aux_q[stc_pkg::AUX_MODE_LSB +: 4];

  // Address decode
  function automatic logic hit(input stc_pkg::stc_req_s r, input logic [2:0] a);
    hit = (r.addr == a);
  endfunction : hit

  wire logic wr_ctrl = req_in.wr && hit(req_in, stc_pkg::ADDR_CONTROL);
  wire logic wr_lo   = req_in.wr && hit(req_in, stc_pkg::ADDR_COUNT_LO);
  wire logic wr_hi   = req_in.wr && hit(req_in, stc_pkg::ADDR_COUNT_HI);
  wire logic wr_stat = req_in.wr && hit(req_in, stc_pkg::ADDR_IRQ_STAT);
  wire logic wr_mask = req_in.wr && hit(req_in, stc_pkg::ADDR_IRQ_MASK);
  wire logic wr_aux  = req_in.wr && hit(req_in, stc_pkg::ADDR_AUX_CTRL);
  wire logic wr_cl   = req_in.wr && hit(req_in, stc_pkg::ADDR_CMP_LO);
  wire logic wr_ch   = req_in.wr && hit(req_in, stc_pkg::ADDR_CMP_HI);
  wire logic rd_lo   = req_in.rd && hit(req_in, stc_pkg::ADDR_COUNT_LO);

  // External source: oscillator when enabled, else the count pin
  wire logic ext_raw = lowpower_osc_enable ? lowpower_osc_in : ext_count_input_in;

  // Synchronised edge needs stages two and three to agree on a rise
  wire logic ext_sync_rise = ext_sync_q[1] && ext_sync_q[2] && !ext_prev_q;
  // Bypass: raw level sampled once, a shorter path with a metastability risk
  wire logic ext_bypass_rise = ext_raw && !raw_prev_q;
  wire logic ext_tick = ext_sync_bypass ? ext_bypass_rise : ext_sync_rise;
  wire logic int_tick = (div4_q == stc_pkg::INSTR_LAST);
  wire logic src_tick = clock_source_select ? ext_tick : int_tick;

  // Prescaler terminal count per selection
  logic [2:0] pre_last;
  always_comb begin
    case (stc_pkg::stc_prescale_e'(prescale_select))
      stc_pkg::STC_PS_1: pre_last = 3'h0;
      stc_pkg::STC_PS_2: pre_last = 3'h1;
      stc_pkg::STC_PS_4: pre_last = 3'h3;
      stc_pkg::STC_PS_8: pre_last = 3'h7;
      default:           pre_last = 3'h0;
    endcase
  end

  wire logic count_tick = counter_on && src_tick && (pre_q == pre_last);
  wire logic special_mode = (compare_unit_mode == stc_pkg::MODE_SPECIAL);
  // Period match restarts the count and raises the trigger from compare logic
  wire logic period_hit = special_mode && counter_on && (count_q == cmp_q);
  wire logic ev_reset = special_mode && (special_trigger_in || period_hit);
  wire logic rollover = count_tick && (count_q == 16'hffff);

  // Prescaler and instruction divider; prescaler clears on control writes
  always_comb begin
    div4_d = 2'(div4_q + 2'h1);
    pre_d  = pre_q;
    if (wr_ctrl || !counter_on) begin
      pre_d = 3'h0;
    end else if (src_tick) begin
      pre_d = (pre_q == pre_last) ? 3'h0 : 3'(pre_q + 3'h1);
    end
  end

  // Count update: software write beats special-event reset beats increment
  always_comb begin
    count_d  = count_q;
    hi_buf_d = hi_buf_q;
    if (wr_hi) begin
      if (wide_access_enable) begin
        hi_buf_d = req_in.wdata;
      end else begin
        count_d[15:8] = req_in.wdata;
      end
    end
    if (wr_lo) begin
      count_d[7:0] = req_in.wdata;
      if (wide_access_enable) begin
        count_d[15:8] = hi_buf_q;
      end
    end
    if (!(wr_lo || wr_hi)) begin
      if (ev_reset) begin
        count_d = stc_pkg::COUNT_RST;
      end else if (count_tick) begin
        count_d = 16'(count_q + 16'h0001);
      end
    end
  end

  // Status: hardware set wins over write-one-to-clear; events never set it
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~req_in.wdata;
    end
    if (rollover && !(wr_lo || wr_hi) && !ev_reset) begin
      stat_d[stc_pkg::IRQ_OVF_BIT] = 1'b1;
    end
  end

  // Read mux; low read in wide mode captures the high byte
  always_comb begin
    rd_buf_d = rd_buf_q;
    if (rd_lo && wide_access_enable) begin
      rd_buf_d = count_q[15:8];
    end
    case (req_in.addr)
      stc_pkg::ADDR_CONTROL:  rdata_d = ctrl_q;
      stc_pkg::ADDR_COUNT_LO: rdata_d = count_q[7:0];
      stc_pkg::ADDR_COUNT_HI: rdata_d = wide_access_enable ? rd_buf_q : count_q[15:8];
      stc_pkg::ADDR_IRQ_STAT: rdata_d = stat_q;
      stc_pkg::ADDR_IRQ_MASK: rdata_d = mask_q;
      stc_pkg::ADDR_AUX_CTRL: rdata_d = aux_q;
      stc_pkg::ADDR_CMP_LO:   rdata_d = cmp_q[7:0];
      stc_pkg::ADDR_CMP_HI:   rdata_d = cmp_q[15:8];
      default:                rdata_d = 8'h00;
    endcase
    if (!req_in.rd) begin
      rdata_d = 8'h00;
    end
  end

  // Plain register writes
  assign ctrl_d = wr_ctrl ? req_in.wdata : ctrl_q;
  assign aux_d  = wr_aux  ? req_in.wdata : aux_q;
  assign mask_d = wr_mask ? req_in.wdata : mask_q;
  assign cmp_d  = {wr_ch ? req_in.wdata : cmp_q[15:8], wr_cl ? req_in.wdata : cmp_q[7:0]};

  // Control and data registers
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q   <= stc_pkg::CONTROL_RST;
      aux_q    <= stc_pkg::AUX_RST;
      mask_q   <= stc_pkg::MASK_RST;
      stat_q   <= 8'h00;
      count_q  <= stc_pkg::COUNT_RST;
      cmp_q    <= stc_pkg::CMP_RST;
      hi_buf_q <= 8'h00;
      rd_buf_q <= 8'h00;
      rdata_q  <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      aux_q    <= aux_d;
      mask_q   <= mask_d;
      stat_q   <= stat_d;
      count_q  <= count_d;
      cmp_q    <= cmp_d;
      hi_buf_q <= hi_buf_d;
      rd_buf_q <= rd_buf_d;
      rdata_q  <= rdata_d;
    end
  end

  // Dividers and input sampling; first sync stage feeds only the second
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div4_q     <= 2'h0;
      pre_q      <= 3'h0;
      ext_sync_q <= 3'h0;
      ext_prev_q <= 1'b0;
      raw_prev_q <= 1'b0;
    end else begin
      div4_q     <= div4_d;
      pre_q      <= pre_d;
      ext_sync_q <= {ext_sync_q[1:0], ext_raw};
      ext_prev_q <= ext_sync_q[1] && ext_sync_q[2];
      raw_prev_q <= ext_raw;
    end
  end

  // Outputs
  assign rdata_out  = rdata_q;
  assign count_out  = count_q;
  assign irq_out    = |(stat_q & mask_q);
  assign timebase_out.std_uses_this = timebase_select_hi;
  assign timebase_out.enh_uses_this = timebase_select_hi || timebase_select_lo;
  // Oscillator enable overrides the port direction bits
  assign osc_pin_input_out = lowpower_osc_enable ? 2'b11 : port_direction_in;

endmodule : stc_timer

`default_nettype wire

// File: rtl/stc_pkg.sv
// Package for the sixteen-bit timer/counter: offsets, fields, reset values, types
package stc_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_COUNT_LO  = 3'h1;
  localparam logic [2:0] ADDR_COUNT_HI  = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STAT  = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK  = 3'h4;
  localparam logic [2:0] ADDR_AUX_CTRL  = 3'h5;
  localparam logic [2:0] ADDR_CMP_LO    = 3'h6;
  localparam logic [2:0] ADDR_CMP_HI    = 3'h7;

  // Control register field positions
  localparam int CTL_ON_BIT      = 0;
  localparam int CTL_CS_BIT      = 1;
  localparam int CTL_SYNC_BIT    = 2;
  localparam int CTL_TB_LO_BIT   = 3;
  localparam int CTL_PS_LSB      = 4;
  localparam int CTL_TB_HI_BIT   = 6;
  localparam int CTL_WIDE_BIT    = 7;

  // Auxiliary control fields: low-power oscillator enable, compare mode
  localparam int AUX_OSC_BIT     = 0;
  localparam int AUX_MODE_LSB    = 4;

  // Interrupt status and mask bit positions
  localparam int IRQ_OVF_BIT     = 0;

  // Reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  AUX_RST     = 8'h00;
  localparam logic [7:0]  MASK_RST    = 8'h00;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] CMP_RST     = 16'hffff;

  // Instruction clock is the system clock divided by four
  localparam int          INSTR_DIV   = 4;
  localparam logic [1:0]  INSTR_LAST  = 2'(INSTR_DIV - 1);

  // Compare mode code that issues the special-event trigger
  localparam logic [3:0]  MODE_SPECIAL = 4'hb;

  // Prescale selection codes
  typedef enum logic [1:0] {
    STC_PS_1 = 2'b00,
    STC_PS_2 = 2'b01,
    STC_PS_4 = 2'b10,
    STC_PS_8 = 2'b11
  } stc_prescale_e;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stc_req_s;

  // Time-base routing to the capture/compare units
  typedef struct packed {
    logic std_uses_this;
    logic enh_uses_this;
  } stc_timebase_s;

endpackage : stc_pkg

// File: test/stc_timer_properties.sv
// Checker: port-level properties of the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module stc_timer_properties (
  // Clock, reset and register port
  input wire logic                   mclk_in,
  input wire logic                   reset_n_in,
  input wire stc_pkg::stc_req_s      req_in,
  input wire logic [7:0]             rdata_out,
  // Count sources and compare side
  input wire logic                   ext_count_input_in,
  input wire logic                   lowpower_osc_in,
  input wire logic                   special_trigger_in,
  input wire logic [15:0]            count_out,
  input wire stc_pkg::stc_timebase_s timebase_out,
  // Pins and interrupt
  input wire logic [1:0]             port_direction_in,
  input wire logic [1:0]             osc_pin_input_out,
  input wire logic                   irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] ctl_q;
  logic [7:0] aux_q;
  logic       msk_q;
  // Shadows of the registers that steer outputs, written at the same edge as the design's
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_q <= 8'h00;
      aux_q <= 8'h00;
      msk_q <= 1'b0;
    end else if (req_in.wr) begin
      if (req_in.addr == stc_pkg::ADDR_CONTROL) ctl_q <= req_in.wdata;
      if (req_in.addr == stc_pkg::ADDR_AUX_CTRL) aux_q <= req_in.wdata;
      if (req_in.addr == stc_pkg::ADDR_IRQ_MASK) msk_q <= req_in.wdata[0];
    end
  end
  // Quiet cycles: nothing but the count clock may move the count
  wire logic cwr = req_in.wr && (req_in.addr == stc_pkg::ADDR_COUNT_LO
                                 || req_in.addr == stc_pkg::ADDR_COUNT_HI);
  wire logic spec = aux_q[7:4] == stc_pkg::MODE_SPECIAL;
  wire logic calm = ctl_q[0] && !special_trigger_in && !cwr && !spec;
  wire logic calm_int = calm && !ctl_q[1] && ctl_q[5:4] == 2'b00 && !req_in.wr;
  sequence s_roll;
    count_out == 16'hffff && calm ##1 count_out == 16'h0000 && msk_q;
  endsequence
  sequence s_tick;
    $changed(count_out) && calm_int && $past(calm_int) ##1 calm_int [*3];
  endsequence
  AST_TICK: assert property (s_tick |=> count_out == $past(count_out, 4) + 16'h0001)
    else $error("internal count step is not four clocks");
  AST_ROLL: assert property (s_roll |-> ##[0:1] irq_out)
    else $error("rollover did not raise the interrupt");
  AST_MASK: assert property (!msk_q |-> !irq_out)
    else $error("interrupt high while masked");
  AST_OFF: assert property (!ctl_q[0] && !special_trigger_in && !cwr |=> $stable(count_out))
    else $error("count moved while stopped");
  AST_SEV: assert property (spec && special_trigger_in && !cwr |=> count_out == 16'h0000)
    else $error("trigger did not clear the count");
  AST_WIN: assert property (special_trigger_in && req_in.wr && !ctl_q[7]
    && req_in.addr == stc_pkg::ADDR_COUNT_LO |=> count_out[7:0] == $past(req_in.wdata))
    else $error("write lost against trigger");
  AST_RDZ: assert property (!req_in.rd |=> rdata_out == 8'h00)
    else $error("read data outside read answer");
  AST_RDC: assert property (req_in.rd && req_in.addr == stc_pkg::ADDR_CONTROL
    |=> rdata_out == $past(ctl_q))
    else $error("control readback wrong");
  AST_TB: assert property (timebase_out.std_uses_this == ctl_q[6]
    && timebase_out.enh_uses_this == (ctl_q[6] | ctl_q[3]))
    else $error("time-base routing wrong");
  AST_OSC: assert property (osc_pin_input_out == (aux_q[0] ? 2'b11 : port_direction_in))
    else $error("oscillator pin direction wrong");
endmodule : stc_timer_properties
bind stc_timer stc_timer_properties i_stc_timer_properties (.mclk_in(mclk_in),
  .reset_n_in(reset_n_in), .req_in(req_in), .rdata_out(rdata_out),
  .ext_count_input_in(ext_count_input_in), .lowpower_osc_in(lowpower_osc_in),
  .special_trigger_in(special_trigger_in), .count_out(count_out),
  .timebase_out(timebase_out), .port_direction_in(port_direction_in),
  .osc_pin_input_out(osc_pin_input_out), .irq_out(irq_out));
`default_nettype wire

// File: test/stc_partner.sv
// Far-side model: external count source and compare-unit trigger
`timescale 1ns/1ps
`default_nettype none
module stc_partner (
  // Clock, reset and commands
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic go_edge_in,
  input  wire logic use_osc_in,
  input  wire logic go_trig_in,
  // Lines towards the timer
  output logic      ext_count_out,
  output logic      osc_out,
  output var logic  trig_out
);
  logic [3:0] cnt_q;
  logic       go_q;
  // Slow pulses so the synchroniser sees each level; trigger is one cycle per command
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q    <= 4'h0;
      go_q     <= 1'b0;
      trig_out <= 1'b0;
    end else begin
      cnt_q    <= go_edge_in ? 4'hc : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      go_q     <= go_trig_in;
      trig_out <= go_trig_in && !go_q;
    end
  end
  // Clock stands low between pulses; unselected source stays low
  assign ext_count_out = !use_osc_in && cnt_q > 4'h6;
  assign osc_out       = use_osc_in && cnt_q > 4'h6;
endmodule : stc_partner
`default_nettype wire

// File: test/test_stc_timer.sv
// Testbench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module test_stc_timer;
  logic clk = 1'b0, rst_n = 1'b0, go_edge = 1'b0, use_osc = 1'b0, go_trig = 1'b0;
  logic [1:0] pdir = 2'b10;
  stc_pkg::stc_req_s req = '0;
  wire logic [7:0] rdata;
  wire logic [15:0] cnt;
  wire logic irq, ext, osc, trig;
  wire stc_pkg::stc_timebase_s tb;
  wire logic [1:0] odir;
  logic [7:0] d;
  int fail_count = 0, checked = 0, n;
  // Ordinary register rows: index, written value, expected readback
  logic [2:0] ra [7] = '{3'h0, 3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3};
  logic [7:0] rw [7] = '{8'h48, 8'h88, 8'h00, 8'hb1, 8'h05, 8'h00, 8'h01};
  logic [7:0] rx [7] = '{8'h48, 8'h88, 8'h00, 8'hb1, 8'h05, 8'h00, 8'h00};
  stc_timer i_stc_timer (.mclk_in(clk), .reset_n_in(rst_n), .req_in(req), .rdata_out(rdata),
    .ext_count_input_in(ext), .lowpower_osc_in(osc), .special_trigger_in(trig),
    .count_out(cnt), .timebase_out(tb), .port_direction_in(pdir), .osc_pin_input_out(odir),
    .irq_out(irq));
  stc_partner i_stc_partner (.mclk_in(clk), .reset_n_in(rst_n), .go_edge_in(go_edge),
    .use_osc_in(use_osc), .go_trig_in(go_trig), .ext_count_out(ext), .osc_out(osc),
    .trig_out(trig));
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycles start one edge in, so strobes never get two values in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // Cycles until the count next changes, or until zero when zero_in is set
  task automatic wchg(input bit zero_in, output int k);
    logic [15:0] p;
    #1 p = cnt;
    for (k = 0; k < 200 && (zero_in ? cnt !== 16'h0 : cnt === p); k++) @(posedge clk) #1;
    if (k >= 200) begin
      fail_count++;
      finish_test;
    end
  endtask : wchg
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk({8'h00, d}, (i > 5) ? 16'h00ff : 16'h0000);
    end
    foreach (ra[i]) begin
      wr(ra[i], rw[i]);
      rd(ra[i], d);
      chk({8'h00, d}, {8'h00, rx[i]});
    end
    // Rows leave code 01 in the time-base field and the oscillator enabled
    chk({14'h0, tb}, 16'h0001);
    chk({14'h0, odir}, 16'h0003);
    // Wide access: high byte waits for the low write, reads pair through the buffer
    wr(stc_pkg::ADDR_COUNT_HI, 8'h56);
    chk(cnt, 16'h0000);
    wr(stc_pkg::ADDR_COUNT_LO, 8'h78);
    chk(cnt, 16'h5678);
    rd(stc_pkg::ADDR_COUNT_LO, d);
    chk({8'h00, d}, 16'h0078);
    rd(stc_pkg::ADDR_COUNT_HI, d);
    chk({8'h00, d}, 16'h0056);
    wr(stc_pkg::ADDR_CONTROL, 8'h40);
    chk({14'h0, tb}, 16'h0003);
    wr(stc_pkg::ADDR_CONTROL, 8'h00);
    chk({14'h0, tb}, 16'h0000);
    wr(stc_pkg::ADDR_COUNT_LO, 8'h34);
    chk(cnt, 16'h5634);
    // Trigger alone clears; trigger beside a write keeps the write
    @(posedge clk) go_trig <= 1'b1;
    repeat (3) @(posedge clk);
    go_trig <= 1'b0;
    #1 chk(cnt, 16'h0000);
    @(posedge clk) go_trig <= 1'b1;
    wr(stc_pkg::ADDR_COUNT_LO, 8'h33);
    go_trig <= 1'b0;
    chk(cnt, 16'h0033);
    // Compare value acts as the period, with no overflow flag
    wr(stc_pkg::ADDR_COUNT_LO, 8'h00);
    wr(stc_pkg::ADDR_CONTROL, 8'h01);
    d = 8'h00;
    repeat (100) @(posedge clk) #1 if (cnt[7:0] > d) d = cnt[7:0];
    chk({8'h00, d}, 16'h0005);
    // Overflow tick and trigger in one cycle: the restart must not set the flag
    wr(stc_pkg::ADDR_COUNT_HI, 8'hff);
    wchg(1'b0, n);
    wr(stc_pkg::ADDR_COUNT_LO, 8'hff);
    go_trig <= 1'b1;
    repeat (2) @(posedge clk);
    go_trig <= 1'b0;
    #1 chk(cnt, 16'h0000);
    rd(stc_pkg::ADDR_IRQ_STAT, d);
    chk({8'h00, d}, 16'h0000);
    wr(stc_pkg::ADDR_AUX_CTRL, 8'h00);
    chk({14'h0, odir}, 16'h0002);
    // Rollover with the interrupt enabled, then masked, then cleared
    wr(stc_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(stc_pkg::ADDR_COUNT_LO, 8'hfc);
    wr(stc_pkg::ADDR_COUNT_HI, 8'hff);
    wchg(1'b1, n);
    chk({15'h0, irq}, 16'h0001);
    wr(stc_pkg::ADDR_IRQ_MASK, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    rd(stc_pkg::ADDR_IRQ_STAT, d);
    chk({8'h00, d}, 16'h0001);
    wr(stc_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(stc_pkg::ADDR_IRQ_MASK, 8'h01);
    chk({15'h0, irq}, 16'h0000);
    // Prescale codes: spacing between steps of the internal count
    for (int ps = 0; ps < 4; ps++) begin
      wr(stc_pkg::ADDR_CONTROL, {2'b00, 2'(ps), 4'h1});
      wchg(1'b0, n);
      wchg(1'b0, n);
      chk(16'(n), 16'(4 << ps));
    end
    // External source synchronised, bypassed, then from the low-power oscillator
    for (int m = 0; m < 3; m++) begin
      wr(stc_pkg::ADDR_CONTROL, (m == 0) ? 8'h03 : 8'h07);
      wr(stc_pkg::ADDR_AUX_CTRL, (m == 2) ? 8'h01 : 8'h00);
      use_osc <= (m == 2);
      wr(stc_pkg::ADDR_COUNT_LO, 8'h00);
      wr(stc_pkg::ADDR_COUNT_HI, 8'h00);
      // Bypass counts two edges after the request, the synchroniser three edges later
      for (int j = 0; j < 3; j++) begin
        @(posedge clk) go_edge <= 1'b1;
        @(posedge clk) go_edge <= 1'b0;
        @(posedge clk) #1 chk(cnt, 16'(j + ((m > 0) ? 1 : 0)));
        repeat (13) @(posedge clk);
      end
      #1 chk(cnt, 16'h0003);
    end
    // Reset in mid-run while counting: count clears and the counter stays stopped
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(cnt, 16'h0000);
    rd(stc_pkg::ADDR_CONTROL, d);
    chk({8'h00, d}, 16'h0000);
    repeat (8) @(posedge clk);
    #1 chk(cnt, 16'h0000);
    finish_test;
  end
endmodule : test_stc_timer
`default_nettype wire
